// ===== hw/gpb_port_bank.v
// Five port groups, all but group one with shared peripheral pin functions, and CPU access
`timescale 1ns/100ps
`include "gpb_consts.vh"

module gpb_port_bank (
  input wire clock_i,
  input wire srst_i,
  input wire [3:0] cpu_addr_i,
  input wire cpu_wr_i,
  input wire cpu_rd_i,
  input wire [7:0] cpu_wdata_i,
  output reg [7:0] cpu_rdata_o,
  output reg cpu_rvalid_o,
  input wire [7:0] port_group_zero_pin_i,
  output wire [7:0] port_group_zero_pin_o,
  output wire [7:0] port_group_zero_pin_oe_n_o,
  input wire [7:0] port_group_one_pin_i,
  output wire [7:0] port_group_one_pin_o,
  output wire [7:0] port_group_one_pin_oe_n_o,
  input wire [7:0] port_group_two_pin_i,
  output wire [7:0] port_group_two_pin_o,
  output wire [7:0] port_group_two_pin_oe_n_o,
  input wire [7:0] port_group_three_pin_i,
  output wire [7:0] port_group_three_pin_o,
  output wire [7:0] port_group_three_pin_oe_n_o,
  input wire [7:0] port_group_four_pin_i,
  output wire [7:0] port_group_four_pin_o,
  output wire [7:0] port_group_four_pin_oe_n_o,
  input wire serial_two_sel_i,
  input wire serial_two_data_out_i,
  input wire serial_two_data_out_oe_i,
  input wire serial_two_clock_out_i,
  input wire serial_two_clock_oe_i,
  input wire serial_two_ready_out_i,
  input wire serial_two_ready_oe_i,
  output wire serial_two_data_in_o,
  output wire serial_two_clock_in_o,
  output wire serial_two_ready_in_o,
  input wire serial_one_sel_i,
  input wire serial_one_txd_i,
  input wire serial_one_txd_oe_i,
  input wire serial_one_clock_sel_i,
  input wire serial_one_clock_out_i,
  input wire serial_one_clock_oe_i,
  input wire serial_one_ready_sel_i,
  input wire serial_one_ready_out_i,
  input wire serial_one_ready_oe_i,
  output wire serial_one_rxd_o,
  output wire serial_one_clock_in_o,
  output wire serial_one_ready_in_o,
  input wire subclock_sel_i,
  input wire bus_one_sel_i,
  input wire bus_one_data_out_i,
  input wire bus_one_clock_out_i,
  output wire bus_one_data_in_o,
  output wire bus_one_clock_in_o,
  input wire bus_two_sel_i,
  input wire bus_two_data_out_i,
  input wire bus_two_clock_out_i,
  output wire second_bus_data_line_o,
  output wire second_bus_clock_line_o,
  input wire timer_x_pin_sel_i,
  input wire timer_x_pin_out_i,
  input wire timer_x_pin_oe_i,
  output wire timer_x_count_pin_o,
  input wire timer_y_pin_sel_i,
  input wire timer_y_pin_out_i,
  input wire timer_y_pin_oe_i,
  output wire timer_y_count_pin_o,
  input wire [4:0] analog_sel_i,
  output wire [4:0] analog_level_o,
  input wire compare_out_sel_i,
  input wire compare_out_i,
  input wire pwm_sel_i,
  input wire pwm_out_i,
  output wire [3:0] ext_int_o
);

  // Address decode for the write strobes; the read mux decodes with its own case
  function hit;
    input [3:0] addr;
    input [3:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  function [7:0] bitmask;
    input cond;
    input integer pos;
    begin
      bitmask = 8'h00;
      bitmask[pos] = cond;
    end
  endfunction

  wire [7:0] g0_sync, g1_sync, g2_sync, g3_sync, g4_sync;
  wire [7:0] g0_rd, g1_rd, g2_rd, g3_rd, g4_rd;

  reg [7:0] g0_alt_sel, g0_alt_out, g0_alt_oe;
  reg [7:0] g2_alt_sel, g2_alt_out, g2_alt_oe, g2_od;
  reg [7:0] g3_alt_sel, g4_alt_sel, g4_alt_out, g4_alt_oe, rdata_next;

  wire g2_serial_txd, g2_serial_rdy;

  // Serial two on the low four pins of group zero
  always @* begin
    g0_alt_sel = 8'h00;
    g0_alt_out = 8'h00;
    g0_alt_oe = 8'h00;
    if (serial_two_sel_i) begin
      g0_alt_sel = 8'h0f;
      g0_alt_out = bitmask(serial_two_data_out_i, `GPB_BIT_S2_DOUT)
        | bitmask(serial_two_clock_out_i, `GPB_BIT_S2_CLK)
        | bitmask(serial_two_ready_out_i, `GPB_BIT_S2_RDY);
      g0_alt_oe = bitmask(serial_two_data_out_oe_i, `GPB_BIT_S2_DOUT)
        | bitmask(serial_two_clock_oe_i, `GPB_BIT_S2_CLK)
        | bitmask(serial_two_ready_oe_i, `GPB_BIT_S2_RDY);
    end
  end

  assign serial_two_data_in_o = g0_sync[`GPB_BIT_S2_DIN];
  assign serial_two_clock_in_o = g0_sync[`GPB_BIT_S2_CLK];
  assign serial_two_ready_in_o = g0_sync[`GPB_BIT_S2_RDY];

  // Second bus wins over serial one on the shared pins four and five
  assign g2_serial_txd = serial_one_sel_i & ~bus_two_sel_i;
  // Serial ready wins over the timer x counter on the top pin
  assign g2_serial_rdy = serial_one_sel_i & serial_one_ready_sel_i;

  always @* begin
    g2_alt_sel = 8'h00;
    g2_alt_out = 8'h00;
    g2_alt_oe = 8'h00;
    g2_od = 8'h00;
    // Oscillator owns both pins; its drive is analog and outside this block
    if (subclock_sel_i) begin
      g2_alt_sel = g2_alt_sel | 8'h03;
    end
    // First bus pins are always open drain
    g2_od = g2_od | bitmask(1'b1, `GPB_BIT_B1_DATA) | bitmask(1'b1, `GPB_BIT_B1_CLK);
    if (bus_one_sel_i) begin
      g2_alt_sel = g2_alt_sel | 8'h0c;
      g2_alt_out = g2_alt_out | bitmask(bus_one_data_out_i, `GPB_BIT_B1_DATA)
        | bitmask(bus_one_clock_out_i, `GPB_BIT_B1_CLK);
      g2_alt_oe = g2_alt_oe | 8'h0c;
    end
    if (bus_two_sel_i) begin
      g2_alt_sel = g2_alt_sel | 8'h30;
      g2_alt_out = g2_alt_out | bitmask(bus_two_data_out_i, `GPB_BIT_B2_DATA)
        | bitmask(bus_two_clock_out_i, `GPB_BIT_B2_CLK);
      g2_alt_oe = g2_alt_oe | 8'h30;
      g2_od = g2_od | 8'h30;
    end else if (g2_serial_txd) begin
      // Receive pin stays an input; transmit pin is push-pull
      g2_alt_sel = g2_alt_sel | 8'h30;
      g2_alt_out = g2_alt_out | bitmask(serial_one_txd_i, `GPB_BIT_B2_CLK);
      g2_alt_oe = g2_alt_oe | bitmask(serial_one_txd_oe_i, `GPB_BIT_B2_CLK);
    end
    if (serial_one_sel_i & serial_one_clock_sel_i) begin
      g2_alt_sel = g2_alt_sel | bitmask(1'b1, `GPB_BIT_S1_CLK);
      g2_alt_out = g2_alt_out | bitmask(serial_one_clock_out_i, `GPB_BIT_S1_CLK);
      g2_alt_oe = g2_alt_oe | bitmask(serial_one_clock_oe_i, `GPB_BIT_S1_CLK);
    end
    if (g2_serial_rdy) begin
      g2_alt_sel = g2_alt_sel | bitmask(1'b1, `GPB_BIT_S1_RDY);
      g2_alt_out = g2_alt_out | bitmask(serial_one_ready_out_i, `GPB_BIT_S1_RDY);
      g2_alt_oe = g2_alt_oe | bitmask(serial_one_ready_oe_i, `GPB_BIT_S1_RDY);
    end else if (timer_x_pin_sel_i) begin
      g2_alt_sel = g2_alt_sel | bitmask(1'b1, `GPB_BIT_S1_RDY);
      g2_alt_out = g2_alt_out | bitmask(timer_x_pin_out_i, `GPB_BIT_S1_RDY);
      g2_alt_oe = g2_alt_oe | bitmask(timer_x_pin_oe_i, `GPB_BIT_S1_RDY);
    end
  end

  assign bus_one_data_in_o = g2_sync[`GPB_BIT_B1_DATA];
  assign bus_one_clock_in_o = g2_sync[`GPB_BIT_B1_CLK];
  assign second_bus_data_line_o = g2_sync[`GPB_BIT_B2_DATA];
  assign second_bus_clock_line_o = g2_sync[`GPB_BIT_B2_CLK];
  assign serial_one_rxd_o = g2_sync[`GPB_BIT_B2_DATA];
  assign serial_one_clock_in_o = g2_sync[`GPB_BIT_S1_CLK];
  assign serial_one_ready_in_o = g2_sync[`GPB_BIT_S1_RDY];
  assign timer_x_count_pin_o = g2_sync[`GPB_BIT_S1_RDY];

  // Analog inputs: the converter takes the pin, the digital driver is off
  always @* begin
    g3_alt_sel = {3'h0, analog_sel_i};
  end

  assign analog_level_o = g3_sync[4:0];

  always @* begin
    g4_alt_sel = 8'h00;
    g4_alt_out = 8'h00;
    g4_alt_oe = 8'h00;
    if (timer_y_pin_sel_i) begin
      g4_alt_sel = g4_alt_sel | bitmask(1'b1, `GPB_BIT_TY_CNT);
      g4_alt_out = g4_alt_out | bitmask(timer_y_pin_out_i, `GPB_BIT_TY_CNT);
      g4_alt_oe = g4_alt_oe | bitmask(timer_y_pin_oe_i, `GPB_BIT_TY_CNT);
    end
    if (compare_out_sel_i) begin
      g4_alt_sel = g4_alt_sel | bitmask(1'b1, `GPB_BIT_SCMP);
      g4_alt_out = g4_alt_out | bitmask(compare_out_i, `GPB_BIT_SCMP);
      g4_alt_oe = g4_alt_oe | bitmask(1'b1, `GPB_BIT_SCMP);
    end
    if (pwm_sel_i) begin
      g4_alt_sel = g4_alt_sel | bitmask(1'b1, `GPB_BIT_PWM);
      g4_alt_out = g4_alt_out | bitmask(pwm_out_i, `GPB_BIT_PWM);
      g4_alt_oe = g4_alt_oe | bitmask(1'b1, `GPB_BIT_PWM);
    end
  end

  assign timer_y_count_pin_o = g4_sync[`GPB_BIT_TY_CNT];
  // Interrupt inputs are always live; edge logic sits in the interrupt block
  assign ext_int_o = g4_sync[`GPB_BIT_INT0 +: 4];

  gpb_port_group u_group_zero (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_data_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G0_DATA)),
    .wr_dir_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G0_DIR)),
    .wdata_i(cpu_wdata_i),
    .pin_i(port_group_zero_pin_i),
    .alt_sel_i(g0_alt_sel),
    .alt_out_i(g0_alt_out),
    .alt_oe_i(g0_alt_oe),
    .od_i(8'h00),
    .pin_o(port_group_zero_pin_o),
    .pin_oe_n_o(port_group_zero_pin_oe_n_o),
    .pin_sync_o(g0_sync),
    .rd_value_o(g0_rd)
  );

  gpb_port_group u_group_one (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_data_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G1_DATA)),
    .wr_dir_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G1_DIR)),
    .wdata_i(cpu_wdata_i),
    .pin_i(port_group_one_pin_i),
    .alt_sel_i(8'h00),
    .alt_out_i(8'h00),
    .alt_oe_i(8'h00),
    .od_i(8'h00),
    .pin_o(port_group_one_pin_o),
    .pin_oe_n_o(port_group_one_pin_oe_n_o),
    .pin_sync_o(g1_sync),
    .rd_value_o(g1_rd)
  );

  gpb_port_group u_group_two (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_data_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G2_DATA)),
    .wr_dir_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G2_DIR)),
    .wdata_i(cpu_wdata_i),
    .pin_i(port_group_two_pin_i),
    .alt_sel_i(g2_alt_sel),
    .alt_out_i(g2_alt_out),
    .alt_oe_i(g2_alt_oe),
    .od_i(g2_od),
    .pin_o(port_group_two_pin_o),
    .pin_oe_n_o(port_group_two_pin_oe_n_o),
    .pin_sync_o(g2_sync),
    .rd_value_o(g2_rd)
  );

  gpb_port_group u_group_three (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_data_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G3_DATA)),
    .wr_dir_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G3_DIR)),
    .wdata_i(cpu_wdata_i & `GPB_SHORT_GROUP_MASK),
    .pin_i(port_group_three_pin_i),
    .alt_sel_i(g3_alt_sel),
    .alt_out_i(8'h00),
    .alt_oe_i(8'h00),
    .od_i(8'h00),
    .pin_o(port_group_three_pin_o),
    .pin_oe_n_o(port_group_three_pin_oe_n_o),
    .pin_sync_o(g3_sync),
    .rd_value_o(g3_rd)
  );

  gpb_port_group u_group_four (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .wr_data_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G4_DATA)),
    .wr_dir_i(cpu_wr_i & hit(cpu_addr_i, `GPB_ADDR_G4_DIR)),
    .wdata_i(cpu_wdata_i & `GPB_SHORT_GROUP_MASK),
    .pin_i(port_group_four_pin_i),
    .alt_sel_i(g4_alt_sel),
    .alt_out_i(g4_alt_out),
    .alt_oe_i(g4_alt_oe),
    .od_i(8'h00),
    .pin_o(port_group_four_pin_o),
    .pin_oe_n_o(port_group_four_pin_oe_n_o),
    .pin_sync_o(g4_sync),
    .rd_value_o(g4_rd)
  );

  // Direction registers are not in the read mux and read zero; absent pins read zero
  always @* begin
    case (cpu_addr_i)
      `GPB_ADDR_G0_DATA: rdata_next = g0_rd;
      `GPB_ADDR_G1_DATA: rdata_next = g1_rd;
      `GPB_ADDR_G2_DATA: rdata_next = g2_rd;
      `GPB_ADDR_G3_DATA: rdata_next = g3_rd & `GPB_SHORT_GROUP_MASK;
      `GPB_ADDR_G4_DATA: rdata_next = g4_rd & `GPB_SHORT_GROUP_MASK;
      default: rdata_next = `GPB_READ_UNMAPPED;
    endcase
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      cpu_rdata_o <= 8'h00;
      cpu_rvalid_o <= 1'b0;
    end else begin
      cpu_rvalid_o <= cpu_rd_i;
      if (cpu_rd_i) begin
        cpu_rdata_o <= rdata_next;
      end
    end
  end

endmodule

// ===== hw/gpb_consts.vh
// Address map, reset values and masks of the port bank
`ifndef GPB_CONSTS_VH
`define GPB_CONSTS_VH

`define GPB_ADDR_W 4
`define GPB_DATA_W 8

`define GPB_ADDR_G0_DATA 4'h0
`define GPB_ADDR_G0_DIR 4'h1
`define GPB_ADDR_G1_DATA 4'h2
`define GPB_ADDR_G1_DIR 4'h3
`define GPB_ADDR_G2_DATA 4'h4
`define GPB_ADDR_G2_DIR 4'h5
`define GPB_ADDR_G3_DATA 4'h6
`define GPB_ADDR_G3_DIR 4'h7
`define GPB_ADDR_G4_DATA 4'h8
`define GPB_ADDR_G4_DIR 4'h9

`define GPB_LATCH_RESET 8'h00
`define GPB_DIR_RESET 8'h00
`define GPB_READ_UNMAPPED 8'h00

`define GPB_SHORT_GROUP_MASK 8'h1f

`define GPB_BIT_S2_DIN 0
`define GPB_BIT_S2_DOUT 1
`define GPB_BIT_S2_CLK 2
`define GPB_BIT_S2_RDY 3
`define GPB_BIT_SUB_OUT 0
`define GPB_BIT_SUB_IN 1
`define GPB_BIT_B1_DATA 2
`define GPB_BIT_B1_CLK 3
`define GPB_BIT_B2_DATA 4
`define GPB_BIT_B2_CLK 5
`define GPB_BIT_S1_CLK 6
`define GPB_BIT_S1_RDY 7
`define GPB_BIT_TY_CNT 0
`define GPB_BIT_INT0 1
`define GPB_BIT_SCMP 3
`define GPB_BIT_PWM 4

`endif

// ===== hw/gpb_port_group.v
// One eight-pin port group: latch, direction, pin synchroniser, pin drive
`timescale 1ns/100ps
`include "gpb_consts.vh"

module gpb_port_group (
  input wire clock_i,
  input wire srst_i,
  input wire wr_data_i,
  input wire wr_dir_i,
  input wire [7:0] wdata_i,
  input wire [7:0] pin_i,
  input wire [7:0] alt_sel_i,
  input wire [7:0] alt_out_i,
  input wire [7:0] alt_oe_i,
  input wire [7:0] od_i,
  output reg [7:0] pin_o,
  output reg [7:0] pin_oe_n_o,
  output wire [7:0] pin_sync_o,
  output wire [7:0] rd_value_o
);

  reg [7:0] latch_reg;
  reg [7:0] dir_reg;
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] drive;
  reg [7:0] level;
  integer b;

  always @(posedge clock_i) begin
    if (srst_i) begin
      latch_reg <= `GPB_LATCH_RESET;
      dir_reg <= `GPB_DIR_RESET;
    end else begin
      if (wr_data_i) begin
        latch_reg <= wdata_i;
      end
      if (wr_dir_i) begin
        dir_reg <= wdata_i;
      end
    end
  end

  // Pins are asynchronous to the system clock
  always @(posedge clock_i) begin
    if (srst_i) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_sync_o = sync2_reg;
  assign rd_value_o = (dir_reg & latch_reg) | (~dir_reg & sync2_reg);

  always @* begin
    for (b = 0; b < 8; b = b + 1) begin
      if (alt_sel_i[b]) begin
        drive[b] = alt_oe_i[b];
        level[b] = alt_out_i[b];
      end else begin
        drive[b] = dir_reg[b];
        level[b] = latch_reg[b];
      end
      // Open drain drives only the low level, the wire floats high
      if (od_i[b]) begin
        pin_o[b] = 1'h0;
        pin_oe_n_o[b] = ~(drive[b] & ~level[b]);
      end else begin
        pin_o[b] = level[b];
        pin_oe_n_o[b] = ~drive[b];
      end
    end
  end

endmodule

// ===== bench/gpb_bank_chk.sv
// Assertion checker bound to the port bank top level
`timescale 1ns/100ps
module gpb_bank_chk (
  input wire clock_i,
  input wire srst_i,
  input wire [3:0] cpu_addr_i,
  input wire cpu_wr_i,
  input wire cpu_rd_i,
  input wire [7:0] cpu_wdata_i,
  input wire [7:0] cpu_rdata_o,
  input wire cpu_rvalid_o,
  input wire [7:0] port_group_zero_pin_i,
  input wire [7:0] port_group_zero_pin_o,
  input wire [7:0] port_group_zero_pin_oe_n_o,
  input wire [7:0] port_group_one_pin_o,
  input wire [7:0] port_group_one_pin_oe_n_o,
  input wire [7:0] port_group_two_pin_o,
  input wire [7:0] port_group_two_pin_oe_n_o,
  input wire [7:0] port_group_three_pin_oe_n_o,
  input wire [7:0] port_group_four_pin_o,
  input wire [7:0] port_group_four_pin_oe_n_o,
  input wire serial_two_sel_i,
  input wire serial_two_data_out_i,
  input wire serial_two_data_out_oe_i,
  input wire serial_two_data_in_o,
  input wire bus_two_sel_i,
  input wire bus_two_data_out_i,
  input wire timer_y_pin_sel_i,
  input wire timer_y_pin_out_i,
  input wire timer_y_pin_oe_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Synchroniser output is only meaningful once two edges have passed since reset
  reg [1:0] settle_reg;
  always @(posedge clock_i) begin
    if (srst_i)
      settle_reg <= 2'h0;
    else if (settle_reg != 2'h3)
      settle_reg <= settle_reg + 2'h1;
  end
  reset_undriven_a: assert property ($fell(srst_i) |-> port_group_one_pin_oe_n_o == 8'hff)
    else $error("pins driven after reset");
  dir_drive_a: assert property (cpu_wr_i && cpu_addr_i == 4'h3 |=>
    port_group_one_pin_oe_n_o == ~$past(cpu_wdata_i)) else $error("direction not applied");
  latch_drive_a: assert property (cpu_wr_i && cpu_addr_i == 4'h2 |=>
    (port_group_one_pin_o | port_group_one_pin_oe_n_o) ==
    ($past(cpu_wdata_i) | port_group_one_pin_oe_n_o)) else $error("latch not on pins");
  out_read_a: assert property (cpu_rd_i && cpu_addr_i == 4'h2 &&
    port_group_one_pin_oe_n_o == 8'h00 |=> cpu_rvalid_o && cpu_rdata_o == $past(port_group_one_pin_o))
    else $error("output read not latch");
  short_group_a: assert property (port_group_three_pin_oe_n_o[7:5] == 3'h7 &&
    port_group_four_pin_oe_n_o[7:5] == 3'h7) else $error("missing pin driven");
  bus_two_od_a: assert property (bus_two_sel_i |-> port_group_two_pin_o[5:4] == 2'h0 &&
    port_group_two_pin_oe_n_o[4] == bus_two_data_out_i) else $error("bus pin not open drain");
  serial_two_out_a: assert property (serial_two_sel_i && serial_two_data_out_oe_i |->
    port_group_zero_pin_o[1] == serial_two_data_out_i && !port_group_zero_pin_oe_n_o[1])
    else $error("serial data out wrong");
  serial_two_in_a: assert property (serial_two_sel_i && settle_reg == 2'h3 |->
    serial_two_data_in_o == $past(port_group_zero_pin_i[0], 2)) else $error("serial data in wrong");
  timer_y_pin_a: assert property (timer_y_pin_sel_i && timer_y_pin_oe_i |->
    port_group_four_pin_o[0] == timer_y_pin_out_i && !port_group_four_pin_oe_n_o[0])
    else $error("timer pin wrong");
  cover property (bus_two_sel_i && !bus_two_data_out_i);
  cover property (serial_two_sel_i && serial_two_data_out_oe_i);
  cover property (cpu_rd_i && cpu_wr_i);
endmodule

bind gpb_port_bank gpb_bank_chk gpb_bank_chk_i (.*);

// ===== bench/gpb_pin_model.sv
// Outside world of one port group: pull-ups plus an optional outside driver
`timescale 1ns/100ps
module gpb_pin_model (
  input wire [7:0] drv_i,
  input wire [7:0] oe_n_i,
  input wire [7:0] ext_i,
  input wire [7:0] ext_en_i,
  output wire [7:0] level_o
);
  // Released pins float up; two drivers resolve as wired-AND, never as a held old value
  assign level_o = ~((~oe_n_i & ~drv_i) | (ext_en_i & ~ext_i));
endmodule

// ===== bench/tb.sv
// Self-checking bench for the port bank
`timescale 1ns/100ps
module tb;
  logic clock_i = 1'h0, srst_i = 1'h1, cpu_wr_i = 1'h0, cpu_rd_i = 1'h0;
  logic [3:0] cpu_addr_i = 4'h0;
  logic [7:0] cpu_wdata_i = 8'h00;
  logic [4:0] analog_sel_i = 5'h00;
  logic serial_two_sel_i = 1'h0, serial_two_data_out_i = 1'h0, serial_two_data_out_oe_i = 1'h0;
  logic serial_two_clock_out_i = 1'h0, serial_two_clock_oe_i = 1'h0, serial_two_ready_out_i = 1'h0;
  logic serial_two_ready_oe_i = 1'h0, serial_one_sel_i = 1'h0, serial_one_txd_i = 1'h0;
  logic serial_one_txd_oe_i = 1'h0, serial_one_clock_sel_i = 1'h0, serial_one_clock_out_i = 1'h0;
  logic serial_one_clock_oe_i = 1'h0, serial_one_ready_sel_i = 1'h0, serial_one_ready_out_i = 1'h0;
  logic serial_one_ready_oe_i = 1'h0, subclock_sel_i = 1'h0, bus_one_sel_i = 1'h0;
  logic bus_one_data_out_i = 1'h0, bus_one_clock_out_i = 1'h0, bus_two_sel_i = 1'h0;
  logic bus_two_data_out_i = 1'h0, bus_two_clock_out_i = 1'h0, timer_x_pin_sel_i = 1'h0;
  logic timer_x_pin_out_i = 1'h0, timer_x_pin_oe_i = 1'h0, timer_y_pin_sel_i = 1'h0;
  logic timer_y_pin_out_i = 1'h0, timer_y_pin_oe_i = 1'h0, compare_out_sel_i = 1'h0;
  logic compare_out_i = 1'h0, pwm_sel_i = 1'h0, pwm_out_i = 1'h0;
  wire [7:0] cpu_rdata_o, port_group_zero_pin_i, port_group_zero_pin_o, port_group_zero_pin_oe_n_o;
  wire [7:0] port_group_one_pin_i, port_group_one_pin_o, port_group_one_pin_oe_n_o;
  wire [7:0] port_group_two_pin_i, port_group_two_pin_o, port_group_two_pin_oe_n_o;
  wire [7:0] port_group_three_pin_i, port_group_three_pin_o, port_group_three_pin_oe_n_o;
  wire [7:0] port_group_four_pin_i, port_group_four_pin_o, port_group_four_pin_oe_n_o;
  wire cpu_rvalid_o, serial_two_data_in_o, serial_two_clock_in_o, serial_two_ready_in_o;
  wire serial_one_rxd_o, serial_one_clock_in_o, serial_one_ready_in_o, bus_one_data_in_o;
  wire bus_one_clock_in_o, second_bus_data_line_o, second_bus_clock_line_o;
  wire timer_x_count_pin_o, timer_y_count_pin_o;
  wire [4:0] analog_level_o;
  wire [3:0] ext_int_o;
  wire [7:0] po [5];
  wire [7:0] pe [5];
  logic [7:0] ext [5] = '{default: 8'h00};
  logic [7:0] ext_en [5] = '{default: 8'h00};
  // Rows: group, direction, latch, outside level, outside enable, read value, active-low drive enables
  logic [51:0] rows [6] = '{52'h0_00_3c_5a_ff_5a_ff, 52'h1_ff_a5_00_00_a5_00,
    52'h2_0c_0c_00_ff_0c_ff, 52'h3_1f_f5_00_e0_15_e0, 52'h4_f0_30_05_0f_15_ef,
    52'h1_0f_f0_55_f0_50_f0};
  logic [3:0] g;
  logic [7:0] dir, lat, ex, en, exp_rd, exp_oe, msk, got;
  int num_errors = 0;
  int checks = 0;

  gpb_port_bank gpb_port_bank_i (.*);
  gpb_pin_model m0 (.drv_i(port_group_zero_pin_o), .oe_n_i(port_group_zero_pin_oe_n_o),
    .ext_i(ext[0]), .ext_en_i(ext_en[0]), .level_o(port_group_zero_pin_i));
  gpb_pin_model m1 (.drv_i(port_group_one_pin_o), .oe_n_i(port_group_one_pin_oe_n_o),
    .ext_i(ext[1]), .ext_en_i(ext_en[1]), .level_o(port_group_one_pin_i));
  gpb_pin_model m2 (.drv_i(port_group_two_pin_o), .oe_n_i(port_group_two_pin_oe_n_o),
    .ext_i(ext[2]), .ext_en_i(ext_en[2]), .level_o(port_group_two_pin_i));
  gpb_pin_model m3 (.drv_i(port_group_three_pin_o), .oe_n_i(port_group_three_pin_oe_n_o),
    .ext_i(ext[3]), .ext_en_i(ext_en[3]), .level_o(port_group_three_pin_i));
  gpb_pin_model m4 (.drv_i(port_group_four_pin_o), .oe_n_i(port_group_four_pin_oe_n_o),
    .ext_i(ext[4]), .ext_en_i(ext_en[4]), .level_o(port_group_four_pin_i));
  assign po[0] = port_group_zero_pin_o;
  assign po[1] = port_group_one_pin_o;
  assign po[2] = port_group_two_pin_o;
  assign po[3] = port_group_three_pin_o;
  assign po[4] = port_group_four_pin_o;
  assign pe[0] = port_group_zero_pin_oe_n_o;
  assign pe[1] = port_group_one_pin_oe_n_o;
  assign pe[2] = port_group_two_pin_oe_n_o;
  assign pe[3] = port_group_three_pin_oe_n_o;
  assign pe[4] = port_group_four_pin_oe_n_o;

  always #12.5 clock_i = ~clock_i;

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task cmp(input logic [7:0] got_v, input logic [7:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  // Ends one idle edge later so back-to-back calls never re-raise the strobe in one step
  task wr(input logic [3:0] a, input logic [7:0] d);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'h1;
    @(posedge clock_i);
    cpu_wr_i <= 1'h0;
    @(posedge clock_i);
  endtask

  task rd(input logic [3:0] a, output logic [7:0] d);
    int n;
    cpu_addr_i <= a;
    cpu_rd_i <= 1'h1;
    @(posedge clock_i);
    cpu_rd_i <= 1'h0;
    n = 0;
    #1;
    while (cpu_rvalid_o !== 1'h1) begin
      n++;
      if (n > 3) begin
        num_errors++;
        complete_run();
      end
      @(posedge clock_i);
      #1;
    end
    d = cpu_rdata_o;
    @(posedge clock_i);
  endtask

  task reset_check;
    srst_i <= 1'h1;
    repeat (16) @(posedge clock_i);
    srst_i <= 1'h0;
    @(posedge clock_i);
    #1;
    for (int i = 0; i < 5; i++) cmp(pe[i], 8'hff);
    @(posedge clock_i);
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    complete_run();
  end

  initial begin
    reset_check();
    for (int r = 0; r < 6; r++) begin
      {g, dir, lat, ex, en, exp_rd, exp_oe} = rows[r];
      msk = (g > 4'h2) ? 8'h1f : 8'hff;
      ext[g] <= ex;
      ext_en[g] <= en;
      wr({g[2:0], 1'h1}, dir);
      wr({g[2:0], 1'h0}, lat);
      repeat (3) @(posedge clock_i);
      rd({g[2:0], 1'h0}, got);
      cmp(got & msk, exp_rd & msk);
      cmp(pe[g], exp_oe);
    end
    wr(4'h3, 8'hff);
    rd(4'h2, got);
    cmp(got, 8'hf0);
    cmp(po[1], 8'hf0);
    // Write and read in one cycle: the read must still see the old latch
    cpu_addr_i <= 4'h2;
    cpu_wdata_i <= 8'h3c;
    cpu_wr_i <= 1'h1;
    cpu_rd_i <= 1'h1;
    @(posedge clock_i);
    cpu_wr_i <= 1'h0;
    cpu_rd_i <= 1'h0;
    @(posedge clock_i);
    #1;
    cmp(cpu_rdata_o, 8'hf0);
    @(posedge clock_i);
    rd(4'h2, got);
    cmp(got, 8'h3c);
    reset_check();
    {serial_two_sel_i, serial_two_data_out_i, serial_two_data_out_oe_i, timer_y_pin_sel_i,
      timer_y_pin_out_i, timer_y_pin_oe_i, bus_two_sel_i, bus_two_clock_out_i,
      serial_one_sel_i, serial_one_clock_sel_i, serial_one_clock_out_i, serial_one_clock_oe_i,
      timer_x_pin_sel_i, timer_x_pin_oe_i} <= '1;
    ext[0] <= 8'h01;
    ext_en[0] <= 8'h01;
    repeat (3) @(posedge clock_i);
    #1;
    cmp({pe[2][7:4], po[2][7:4]}, 8'h24);
    cmp({pe[0][1], po[0][1], serial_two_data_in_o, pe[4][0], po[4][0], 3'h0}, 8'h68);
    @(posedge clock_i);
    // Serial one off too, so the transmit pin falls back to the port latch
    bus_two_sel_i <= 1'h0;
    serial_one_sel_i <= 1'h0;
    wr(4'h5, 8'h2c);
    wr(4'h4, 8'h2c);
    cmp({6'h00, pe[2][5], po[2][5]}, 8'h01);
    {subclock_sel_i, compare_out_sel_i, compare_out_i, pwm_sel_i, pwm_out_i,
      serial_one_ready_sel_i, serial_one_ready_out_i, serial_one_ready_oe_i,
      serial_two_clock_out_i, serial_two_clock_oe_i, serial_two_ready_oe_i,
      bus_one_sel_i, serial_one_sel_i, serial_one_txd_i, serial_one_txd_oe_i} <= '1;
    analog_sel_i <= 5'h1f;
    @(posedge clock_i);
    #1;
    cmp(pe[3], 8'hff);
    cmp(pe[4], 8'he6);
    cmp(po[4] & 8'h19, 8'h19);
    cmp(pe[0], 8'hf1);
    cmp(po[0] & 8'h0e, 8'h06);
    cmp(pe[2], 8'h13);
    cmp(po[2] & 8'hec, 8'he0);
    @(posedge clock_i);
    ext_en[2] <= 8'h00;
    repeat (3) @(posedge clock_i);
    #1;
    cmp({timer_y_count_pin_o, ext_int_o, serial_two_clock_in_o, serial_two_ready_in_o,
      timer_x_count_pin_o}, 8'hd5);
    cmp({serial_one_rxd_o, serial_one_clock_in_o, serial_one_ready_in_o, bus_one_data_in_o,
      bus_one_clock_in_o, second_bus_data_line_o, second_bus_clock_line_o, 1'h0}, 8'he6);
    cmp({3'h0, analog_level_o}, 8'h1f);
    complete_run();
  end
endmodule
